// file: shared/bba_consts.svh
// constants for the byte/bit alu instruction subset core
`ifndef BBA_CONSTS_SVH
`define BBA_CONSTS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define BBA_INSTR_W       14
`define BBA_DATA_W        8
`define BBA_ADDR_W        7
`define BBA_REG_DEPTH     128

// ----------------------------------------------------------------
// opcode fields, upper bits of the 14-bit word
// ----------------------------------------------------------------
`define BBA_OPC_ADD_IMM   5'h1F
`define BBA_OPC_AND_IMM   6'h39
`define BBA_OPC_ADD_REG   6'h07
`define BBA_OPC_AND_REG   6'h05
`define BBA_OPC_CLR_BIT   4'h4
`define BBA_OPC_SET_BIT   4'h5
`define BBA_OPC_SKIP_CLR  4'h6

// ----------------------------------------------------------------
// special file register addresses
// ----------------------------------------------------------------
`define BBA_ADDR_TIMER    7'h01
`define BBA_ADDR_PTR_LOW  7'h02
`define BBA_ADDR_STATUS   7'h03
`define BBA_ADDR_PORT     7'h05

// ----------------------------------------------------------------
// status bit positions and reset values
// ----------------------------------------------------------------
`define BBA_STAT_C        0
`define BBA_STAT_DC       1
`define BBA_STAT_Z        2
`define BBA_ACC_RST       8'h00
`define BBA_PORT_RST      8'h00
`define BBA_TIMER_RST     8'h00
`define BBA_FLAGS_RST     3'h0

`endif

// file: shared/bba_pkg.sv
// types shared by the byte/bit alu instruction subset core
package bba_pkg;

   typedef enum logic [2:0] {
      op_none,
      op_add_imm,
      op_and_imm,
      op_add_reg,
      op_and_reg,
      op_clr_bit,
      op_set_bit,
      op_skip_clr
   } bba_op_type;

   typedef enum logic {
      st_idle,
      st_exec
   } bba_state_type;

   typedef struct packed {
      bba_op_type  op;
      logic        dest;
      logic [6:0]  faddr;
      logic [2:0]  bidx;
      logic [7:0]  lit;
   } bba_dec_type;

   typedef struct packed {
      logic z;
      logic dc;
      logic c;
   } bba_flags_type;

endpackage

// file: hw/bba_regmem.sv
// file register storage with registered read data
`timescale 1ns/1ns
module bba_regmem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 128,
   parameter int AW    = 7
) (
   input  wire logic             mclk_in,
   input  wire logic             wr_en_in,
   input  wire logic [AW-1:0]    wr_addr_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   input  wire logic [AW-1:0]    rd_addr_in,
   output logic      [WIDTH-1:0] rd_data_out
);

   if (DEPTH > (1 << AW) || WIDTH < 1) begin : g_chk
      $error("bba_regmem: depth does not fit the address width");
   end

   logic [WIDTH-1:0] mem_ff [DEPTH];

   // no reset: contents are undefined until software writes them
   always_ff @(posedge mclk_in) begin
      if (wr_en_in) begin
         mem_ff[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem_ff[rd_addr_in];
   end

endmodule

// file: hw/bba_alu.sv
// result, flag and destination logic for the instruction subset
`timescale 1ns/1ns
module bba_alu import bba_pkg::*; (
   input  bba_dec_type        dec_in,
   input  wire logic [7:0]    acc_in,
   input  wire logic [7:0]    opnd_in,
   output logic      [7:0]    result_out,
   output bba_flags_type      flags_out,
   output logic               upd_carry_out,
   output logic               upd_zero_out,
   output logic               to_file_out,
   output logic               to_acc_out,
   output logic               skip_out
);

   function automatic logic is_zero(input logic [7:0] v);
      return (v == 8'h00);
   endfunction

   logic        lit_op;
   logic [7:0]  addend;
   logic [8:0]  sum;
   logic [4:0]  nib;
   logic [7:0]  conj;
   logic [7:0]  bit_mask;

   assign lit_op   = (dec_in.op == op_add_imm) || (dec_in.op == op_and_imm);
   assign addend   = lit_op ? dec_in.lit : opnd_in;
   assign sum      = {1'b0, acc_in} + {1'b0, addend};
   assign nib      = {1'b0, acc_in[3:0]} + {1'b0, addend[3:0]};
   assign conj     = acc_in & addend;
   assign bit_mask = 8'h01 << dec_in.bidx;

   always_comb begin
      result_out    = opnd_in;
      flags_out     = '0;
      upd_carry_out = 1'b0;
      upd_zero_out  = 1'b0;
      to_file_out   = 1'b0;
      to_acc_out    = 1'b0;
      skip_out      = 1'b0;
      case (dec_in.op)
         op_add_imm, op_add_reg: begin
            result_out    = sum[7:0];
            flags_out.c   = sum[8];
            flags_out.dc  = nib[4];
            flags_out.z   = is_zero(sum[7:0]);
            upd_carry_out = 1'b1;
            upd_zero_out  = 1'b1;
            to_file_out   = (dec_in.op == op_add_reg) && dec_in.dest;
            to_acc_out    = !to_file_out;
         end
         op_and_imm, op_and_reg: begin
            result_out   = conj;
            flags_out.z  = is_zero(conj);
            upd_zero_out = 1'b1;
            to_file_out  = (dec_in.op == op_and_reg) && dec_in.dest;
            to_acc_out   = !to_file_out;
         end
         op_clr_bit: begin
            result_out  = opnd_in & ~bit_mask;
            to_file_out = 1'b1;
         end
         op_set_bit: begin
            result_out  = opnd_in | bit_mask;
            to_file_out = 1'b1;
         end
         op_skip_clr: begin
            skip_out = !(|(opnd_in & bit_mask));
         end
         default: begin
            result_out = opnd_in;
         end
      endcase
   end

endmodule

// file: hw/bba_core.sv
// execution core for the add/and/bit-clear/bit-set/skip subset
`timescale 1ns/1ns
`include "bba_consts.svh"
module bba_core import bba_pkg::*; #(
   parameter int REG_DEPTH = `BBA_REG_DEPTH
) (
   input  wire logic        mclk_in,
   input  wire logic        nrst_in,
   input  wire logic        instr_valid_in,
   input  wire logic [13:0] instr_word_in,
   input  wire logic [7:0]  port_pins_in,
   input  wire logic        presc_to_timer_in,
   output logic             ready_out,
   output logic             done_out,
   output logic             nop_cycle_out,
   output logic             bad_op_out,
   output logic [7:0]       acc_out,
   output bba_flags_type    flags_out,
   output logic [7:0]       port_latch_out,
   output logic [7:0]       timer_count_out,
   output logic             presc_clear_out,
   output logic             ptr_load_out,
   output logic [7:0]       ptr_value_out
);

   if (REG_DEPTH < 8 || REG_DEPTH > `BBA_REG_DEPTH) begin : g_chk
      $error("bba_core: register depth out of range");
   end

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_ff;
   logic       rst_n;

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_sync_ff <= 2'b00;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_ff[1];

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   function automatic bba_dec_type decode(input logic [13:0] w);
      bba_dec_type d;
      d.dest  = w[7];
      d.faddr = w[6:0];
      d.bidx  = w[9:7];
      d.lit   = w[7:0];
      d.op    = op_none;
      if (w[13:9] == `BBA_OPC_ADD_IMM) begin
         d.op = op_add_imm;
      end else if (w[13:8] == `BBA_OPC_AND_IMM) begin
         d.op = op_and_imm;
      end else if (w[13:8] == `BBA_OPC_ADD_REG) begin
         d.op = op_add_reg;
      end else if (w[13:8] == `BBA_OPC_AND_REG) begin
         d.op = op_and_reg;
      end else if (w[13:10] == `BBA_OPC_CLR_BIT) begin
         d.op = op_clr_bit;
      end else if (w[13:10] == `BBA_OPC_SET_BIT) begin
         d.op = op_set_bit;
      end else if (w[13:10] == `BBA_OPC_SKIP_CLR) begin
         d.op = op_skip_clr;
      end
      return d;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   bba_state_type  state_ff;
   bba_state_type  nxt_state;
   logic [13:0]    instr_ff;
   logic           skip_ff;
   logic           ready_ff;
   logic           done_ff;
   logic           nop_ff;
   logic           bad_op_ff;
   logic [7:0]     acc_ff;
   bba_flags_type  flags_ff;
   logic [7:0]     port_latch_ff;
   logic [7:0]     timer_ff;
   logic           presc_clr_ff;
   logic           ptr_load_ff;
   logic [7:0]     ptr_value_ff;

   bba_dec_type    dec;
   logic           accept;
   logic           discard;
   logic           exec;
   logic [7:0]     mem_rd;
   logic [7:0]     opnd;
   logic [7:0]     result;
   bba_flags_type  alu_flags;
   logic           upd_carry;
   logic           upd_zero;
   logic           to_file;
   logic           to_acc;
   logic           alu_skip;

   assign dec     = decode(instr_ff);
   assign accept  = instr_valid_in && ready_ff;
   assign discard = accept && skip_ff;
   assign exec    = (state_ff == st_exec);

   // the operand read is launched on accept so data is ready in exec
   assign nxt_state = (state_ff == st_idle && accept && !skip_ff) ?
                      st_exec : st_idle;

   // ----------------------------------------------------------------
   // operand select
   // ----------------------------------------------------------------
   logic [7:0] stat_byte;
   logic       hit_port;
   logic       hit_timer;
   logic       hit_status;
   logic       hit_ptr;

   // port, timer and status registers live outside the memory, so their decode is
   // shared by the operand mux and the write-back steering
   assign hit_port   = (dec.faddr == `BBA_ADDR_PORT);
   assign hit_timer  = (dec.faddr == `BBA_ADDR_TIMER);
   assign hit_status = (dec.faddr == `BBA_ADDR_STATUS);
   assign hit_ptr    = (dec.faddr == `BBA_ADDR_PTR_LOW);
   assign stat_byte  = {5'h00, flags_ff.z, flags_ff.dc, flags_ff.c};

   // port reads see the pins, so a pin held low by the outside world
   // is written back as zero even if its latch holds one
   assign opnd = hit_port   ? port_pins_in :
                 hit_timer  ? timer_ff :
                 hit_status ? stat_byte :
                 mem_rd;

   bba_alu u_alu (
      .dec_in        (dec),
      .acc_in        (acc_ff),
      .opnd_in       (opnd),
      .result_out    (result),
      .flags_out     (alu_flags),
      .upd_carry_out (upd_carry),
      .upd_zero_out  (upd_zero),
      .to_file_out   (to_file),
      .to_acc_out    (to_acc),
      .skip_out      (alu_skip)
   );

   // ----------------------------------------------------------------
   // write-back targets
   // ----------------------------------------------------------------
   logic           file_wr;
   logic           wr_port;
   logic           wr_timer;
   logic           wr_status;
   logic           wr_ptr;
   logic           mem_we;
   logic           two_cycle;
   bba_flags_type  base_flags;
   bba_flags_type  nxt_flags;
   logic [7:0]     nxt_acc;

   assign file_wr   = exec && to_file;
   assign wr_port   = file_wr && hit_port;
   assign wr_timer  = file_wr && hit_timer;
   assign wr_status = file_wr && hit_status;
   assign wr_ptr    = file_wr && hit_ptr;
   assign mem_we    = file_wr && !wr_port && !wr_timer && !wr_status;

   // a pointer write or a taken skip voids the next instruction
   assign two_cycle = exec && (alu_skip || wr_ptr);

   assign nxt_acc   = (exec && to_acc) ? result : acc_ff;

   // flag updates from the operation win over a write to status
   assign base_flags.c  = wr_status ? result[`BBA_STAT_C]  : flags_ff.c;
   assign base_flags.dc = wr_status ? result[`BBA_STAT_DC] : flags_ff.dc;
   assign base_flags.z  = wr_status ? result[`BBA_STAT_Z]  : flags_ff.z;
   assign nxt_flags.c   = (exec && upd_carry) ? alu_flags.c  :
                          base_flags.c;
   assign nxt_flags.dc  = (exec && upd_carry) ? alu_flags.dc :
                          base_flags.dc;
   assign nxt_flags.z   = (exec && upd_zero)  ? alu_flags.z  :
                          base_flags.z;

   // the read address is the offered word itself, so the operand sits
   // in the memory's output register when the execute cycle starts
   bba_regmem #(
      .WIDTH (`BBA_DATA_W),
      .DEPTH (REG_DEPTH),
      .AW    (`BBA_ADDR_W)
   ) u_mem (
      .mclk_in     (mclk_in),
      .wr_en_in    (mem_we),
      .wr_addr_in  (dec.faddr),
      .wr_data_in  (result),
      .rd_addr_in  (instr_word_in[6:0]),
      .rd_data_out (mem_rd)
   );

   // ----------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= st_idle;
         ready_ff <= 1'b0;
         done_ff  <= 1'b0;
         nop_ff   <= 1'b0;
         skip_ff  <= 1'b0;
         instr_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         ready_ff <= (nxt_state == st_idle);
         done_ff  <= exec;
         nop_ff   <= discard;
         if (two_cycle) begin
            skip_ff <= 1'b1;
         end else if (discard) begin
            skip_ff <= 1'b0;
         end
         if (accept && !skip_ff) begin
            instr_ff <= instr_word_in;
         end
      end
   end

   // ----------------------------------------------------------------
   // architectural registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         acc_ff        <= `BBA_ACC_RST;
         flags_ff      <= `BBA_FLAGS_RST;
         port_latch_ff <= `BBA_PORT_RST;
         timer_ff      <= `BBA_TIMER_RST;
         bad_op_ff     <= 1'b0;
      end else begin
         acc_ff    <= nxt_acc;
         flags_ff  <= nxt_flags;
         bad_op_ff <= exec && (dec.op == op_none);
         if (wr_port) begin
            port_latch_ff <= result;
         end
         if (wr_timer) begin
            timer_ff <= result;
         end
      end
   end

   // ----------------------------------------------------------------
   // side effects toward timer and instruction pointer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         presc_clr_ff <= 1'b0;
         ptr_load_ff  <= 1'b0;
         ptr_value_ff <= 8'h00;
      end else begin
         presc_clr_ff <= wr_timer && presc_to_timer_in;
         ptr_load_ff  <= wr_ptr;
         if (wr_ptr) begin
            ptr_value_ff <= result;
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs, each straight from its register
   // ----------------------------------------------------------------

   assign ready_out       = ready_ff;
   assign done_out        = done_ff;
   assign nop_cycle_out   = nop_ff;
   assign bad_op_out      = bad_op_ff;
   assign acc_out         = acc_ff;
   assign flags_out       = flags_ff;
   assign port_latch_out  = port_latch_ff;
   assign timer_count_out = timer_ff;
   assign presc_clear_out = presc_clr_ff;
   assign ptr_load_out    = ptr_load_ff;
   assign ptr_value_out   = ptr_value_ff;

endmodule

// file: verif/bba_core_sva.sv
// assertion checker for the instruction subset core ports
`timescale 1ns/1ns
module bba_core_sva import bba_pkg::*; #(
   parameter int REG_DEPTH = 128
) (
   input wire logic        mclk_in,
   input wire logic        nrst_in,
   input wire logic        instr_valid_in,
   input wire logic [13:0] instr_word_in,
   input wire logic [7:0]  port_pins_in,
   input wire logic        presc_to_timer_in,
   input wire logic        ready_out,
   input wire logic        done_out,
   input wire logic        nop_cycle_out,
   input wire logic        bad_op_out,
   input wire logic [7:0]  acc_out,
   input bba_flags_type    flags_out,
   input wire logic [7:0]  port_latch_out,
   input wire logic [7:0]  timer_count_out,
   input wire logic        presc_clear_out,
   input wire logic        ptr_load_out,
   input wire logic [7:0]  ptr_value_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   // ------------------------------------------------------------
   // handshake and timing
   // ------------------------------------------------------------
   take_busy_a: assert property (ready_out && instr_valid_in |=>
      !ready_out || nop_cycle_out) else $error("take did not go busy");
   exec_two_a: assert property (ready_out && instr_valid_in ##1
      !ready_out |=> done_out && ready_out) else $error("late finish");
   done_pulse_a: assert property (done_out |=> !done_out)
      else $error("done longer than a cycle");
   discard_keep_a: assert property (nop_cycle_out |->
      ready_out && !done_out && $past(instr_valid_in))
      else $error("discard without a take");
   // ------------------------------------------------------------
   // state changes only at completion
   // ------------------------------------------------------------
   acc_hold_a: assert property ($changed(acc_out) ||
      $changed(flags_out) |-> done_out) else $error("acc moved early");
   port_hold_a: assert property ($changed(port_latch_out) |->
      done_out) else $error("latch moved early");
   timer_clear_a: assert property ($changed(timer_count_out) &&
      presc_to_timer_in |-> presc_clear_out) else $error("no clear");
   presc_cause_a: assert property (presc_clear_out |->
      done_out && $past(presc_to_timer_in)) else $error("stray clear");
   ptr_load_a: assert property (ptr_load_out |-> done_out ##1
      !ptr_load_out) else $error("pointer load out of place");
   bad_op_a: assert property (bad_op_out |-> done_out &&
      !ptr_load_out && !presc_clear_out) else $error("stray bad op");
   cover property (done_out);
   cover property (nop_cycle_out);
   cover property (presc_clear_out);
   cover property (ptr_load_out);
endmodule

bind bba_core bba_core_sva #(.REG_DEPTH(REG_DEPTH)) bba_core_sva_inst (
   .mclk_in(mclk_in), .nrst_in(nrst_in), .instr_valid_in(instr_valid_in),
   .instr_word_in(instr_word_in), .port_pins_in(port_pins_in),
   .presc_to_timer_in(presc_to_timer_in), .ready_out(ready_out),
   .done_out(done_out), .nop_cycle_out(nop_cycle_out),
   .bad_op_out(bad_op_out), .acc_out(acc_out), .flags_out(flags_out),
   .port_latch_out(port_latch_out), .timer_count_out(timer_count_out),
   .presc_clear_out(presc_clear_out), .ptr_load_out(ptr_load_out),
   .ptr_value_out(ptr_value_out));

// file: verif/byte_bit_alu_instr_subset_tb.sv
// self-checking bench for the instruction subset core
`timescale 1ns/1ns
`include "bba_consts.svh"
module byte_bit_alu_instr_subset_tb import bba_pkg::*; ();
   logic          mclk_in = 1'h0;
   logic          nrst_in = 1'h0;
   logic          instr_valid_in = 1'h0;
   logic [13:0]   instr_word_in = 14'h0000;
   logic [7:0]    port_pins_in = 8'h00;
   logic          presc_to_timer_in = 1'h0;
   logic          ready_out, done_out, nop_cycle_out, bad_op_out;
   logic          presc_clear_out, ptr_load_out;
   logic [7:0]    acc_out, port_latch_out, timer_count_out, ptr_value_out;
   bba_flags_type flags_out;
   logic [7:0]    m_mem [0:127];
   logic [7:0]    m_acc = 8'h00, m_lat = 8'h00, m_tim = 8'h00;
   bba_flags_type m_fl = 3'h0;
   logic          m_skip = 1'h0;
   int            error_cnt = 0, samples_checked = 0;
   // only addresses with a known value are read, memory has no reset
   logic [6:0]    adr [0:8] = '{7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25,
                                7'h01, 7'h02, 7'h05};

   always #50 mclk_in = ~mclk_in;

   bba_core bba_core_inst (
      .mclk_in(mclk_in), .nrst_in(nrst_in), .instr_valid_in(instr_valid_in),
      .instr_word_in(instr_word_in), .port_pins_in(port_pins_in),
      .presc_to_timer_in(presc_to_timer_in), .ready_out(ready_out),
      .done_out(done_out), .nop_cycle_out(nop_cycle_out),
      .bad_op_out(bad_op_out), .acc_out(acc_out), .flags_out(flags_out),
      .port_latch_out(port_latch_out), .timer_count_out(timer_count_out),
      .presc_clear_out(presc_clear_out), .ptr_load_out(ptr_load_out),
      .ptr_value_out(ptr_value_out));

   // ------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // expected {nibble carry, carry, sum} of an 8-bit addition
   function automatic logic [9:0] exp_add(input logic [7:0] x,
                                          input logic [7:0] y);
      logic [4:0] lo;
      lo = {1'h0, x[3:0]} + {1'h0, y[3:0]};
      return {lo[4], {1'h0, x} + {1'h0, y}};
   endfunction

   // ------------------------------------------------------------
   // one instruction: drive, predict, compare
   // ------------------------------------------------------------
   task automatic step(input logic [13:0] w);
      logic [7:0] a, o, r;
      logic [8:0] s;
      logic       ad, an, dst, wr, sk, bd;
      int         n;
      @(posedge mclk_in);
      instr_valid_in    <= 1'h1;
      instr_word_in     <= w;
      port_pins_in      <= 8'($urandom);
      presc_to_timer_in <= 1'($urandom);
      @(posedge mclk_in);
      instr_valid_in <= 1'h0;
      #1;
      if (m_skip) begin
         chk(nop_cycle_out, 8'h01);
         chk(ready_out, 8'h01);
         m_skip = 1'h0;
         return;
      end
      a = (w[6:0] == `BBA_ADDR_PORT) ? port_pins_in :
          (w[6:0] == `BBA_ADDR_TIMER) ? m_tim :
          (w[6:0] == `BBA_ADDR_STATUS) ? {5'h00, m_fl} : m_mem[w[6:0]];
      {ad, an, dst, wr, sk, bd} = 6'h00;
      o = a;
      r = a;
      if (w[13:9] == `BBA_OPC_ADD_IMM) {ad, o} = {1'h1, w[7:0]};
      else if (w[13:8] == `BBA_OPC_AND_IMM) {an, o} = {1'h1, w[7:0]};
      else if (w[13:8] == `BBA_OPC_ADD_REG) {ad, dst} = {1'h1, w[7]};
      else if (w[13:8] == `BBA_OPC_AND_REG) {an, dst} = {1'h1, w[7]};
      else if (w[13:10] == `BBA_OPC_CLR_BIT) {wr, r[w[9:7]]} = 2'h2;
      else if (w[13:10] == `BBA_OPC_SET_BIT) {wr, r[w[9:7]]} = 2'h3;
      else if (w[13:10] == `BBA_OPC_SKIP_CLR) sk = !a[w[9:7]];
      else bd = 1'h1;
      if (ad) begin
         {m_fl.dc, s} = exp_add(m_acc, o);
         r = s[7:0];
         m_fl.c = s[8];
      end
      if (an) r = m_acc & o;
      if (ad | an) m_fl.z = (r == 8'h00);
      if ((ad | an) & !dst) m_acc = r;
      else if (ad | an) wr = 1'h1;
      chk(ready_out, 8'h00);
      n = 0;
      while (done_out !== 1'h1 && n < 4) begin
         @(posedge mclk_in);
         #1;
         n++;
      end
      if (wr && w[6:0] == `BBA_ADDR_PORT) m_lat = r;
      else if (wr && w[6:0] == `BBA_ADDR_TIMER) m_tim = r;
      else if (wr && w[6:0] == `BBA_ADDR_STATUS) m_fl = r[2:0];
      else if (wr) m_mem[w[6:0]] = r;
      chk(done_out, 8'h01);
      chk(bad_op_out, bd);
      chk(acc_out, m_acc);
      chk(flags_out, m_fl);
      chk(port_latch_out, m_lat);
      chk(timer_count_out, m_tim);
      chk(presc_clear_out, wr && w[6:0] == 7'h01 && presc_to_timer_in);
      chk(ptr_load_out, wr && w[6:0] == `BBA_ADDR_PTR_LOW);
      if (wr && w[6:0] == `BBA_ADDR_PTR_LOW) chk(ptr_value_out, r);
      m_skip = sk | (wr && w[6:0] == `BBA_ADDR_PTR_LOW);
   endtask

   // zero the acc, and it in so the register is defined, then add k
   task automatic load(input logic [6:0] f, input logic [7:0] k);
      step({`BBA_OPC_AND_IMM, 8'h00});
      step({`BBA_OPC_AND_REG, 1'h1, f});
      step({`BBA_OPC_ADD_IMM, 1'h0, k});
      step({`BBA_OPC_ADD_REG, 1'h1, f});
   endtask

   task automatic rnd();
      logic [6:0] f;
      logic [2:0] b;
      logic [7:0] k;
      f = adr[$urandom_range(8)];
      b = 3'($urandom);
      k = 8'($urandom);
      case ($urandom_range(6))
         0: step({`BBA_OPC_ADD_IMM, 1'h0, k});
         1: step({`BBA_OPC_AND_IMM, k});
         2: step({`BBA_OPC_ADD_REG, k[0], f});
         3: step({`BBA_OPC_AND_REG, k[0], f});
         4: step({`BBA_OPC_CLR_BIT, b, f});
         5: step({`BBA_OPC_SET_BIT, b, f});
         default: step({`BBA_OPC_SKIP_CLR, b, f});
      endcase
   endtask

   initial begin
      void'($urandom(32'h4779));
      repeat (2) @(posedge mclk_in);
      nrst_in <= 1'h1;
      repeat (4) @(posedge mclk_in);
      for (int i = 0; i < 9; i++) load(adr[i], 8'($urandom));
      step({`BBA_OPC_AND_IMM, 8'h00});
      step({`BBA_OPC_ADD_IMM, 1'h0, 8'h01});
      step({`BBA_OPC_ADD_IMM, 1'h0, 8'hFF});
      step({`BBA_OPC_CLR_BIT, 3'h7, 7'h20});
      step({`BBA_OPC_SKIP_CLR, 3'h7, 7'h20});
      step({`BBA_OPC_ADD_IMM, 1'h0, 8'h55});
      step({`BBA_OPC_SET_BIT, 3'h7, 7'h20});
      step({`BBA_OPC_SKIP_CLR, 3'h7, 7'h20});
      step({`BBA_OPC_ADD_IMM, 1'h0, 8'h55});
      step(14'h0000);
      step({`BBA_OPC_SET_BIT, 3'h0, `BBA_ADDR_STATUS});
      step({`BBA_OPC_CLR_BIT, 3'h0, `BBA_ADDR_STATUS});
      for (int i = 0; i < 400; i++) rnd();
      wrap_up();
   end

   // far beyond the roughly 1350 cycles the sequence needs
   initial begin
      #2000000;
      error_cnt++;
      wrap_up();
   end
endmodule
